// ===== verilog/cpwm_pkg.sv
// constants shared by the carrier pwm generator
// How it works
// - the carrier starts at zero, spans zero to one, and an output is active while its index exceeds it.
// - the carrier frequency is the nominal frequency times one scale input shared by all channels.
// - every generator leaves reset of its counter on one common start trigger so carriers align.
// - the carrier is either a sawtooth or a symmetrical up-down wave.
// - an adc trigger and a task trigger, each enabled apart, are raised on carrier events.
// - a trigger is sent only after the repetition period of selected carrier events has passed.
// - with a symmetrical carrier the triggers land on underflow or overflow as selected.
// - a break event shuts every output down to its passive level.
// - the break input is disabled, active low on a falling edge, or active high on a rising edge.
// - a complementary pair gets a blanking delay between one output falling and the other rising.
// - enables act per channel or per output, and an enable at zero makes the gated outputs passive.
// - a polarity bit sets the level each output drives in the active state.
// - each channel gives a single output or a complementary pair, for up to four channels.
// - with external sync on, the chosen sync edge starts and resets the counter.
package cpwm_pkg;
  localparam int NCH = 4;
  localparam int AW = 6;
  // register byte offsets
  localparam logic [AW-1:0] A_CTRL = 6'h00;
  localparam logic [AW-1:0] A_INC = 6'h04;
  localparam logic [AW-1:0] A_MOD0 = 6'h08;
  localparam logic [AW-1:0] A_BLANK = 6'h18;
  localparam logic [AW-1:0] A_CHCFG = 6'h1c;
  localparam logic [AW-1:0] A_REP = 6'h20;
  localparam logic [AW-1:0] A_STAT = 6'h24;
  localparam logic [AW-1:0] A_MASK = 6'h28;
  localparam logic [AW-1:0] A_STATE = 6'h2c;
  // control fields
  localparam int C_ARM = 0;
  localparam int C_SYM = 1;
  localparam int C_BRK = 2; // two bits
  localparam int C_SYNC = 4;
  localparam int C_SFALL = 5;
  localparam int C_OVF = 6;
  localparam int C_ADC = 7;
  localparam int C_TASK = 8;
  localparam int C_PEROUT = 9;
  localparam int C_ENUSE = 10;
  localparam int C_FVAR = 11;
  localparam int C_BCLR = 12;
  localparam int CTRL_W = 12;
  // status bits
  localparam int S_ADC = 0;
  localparam int S_TASK = 1;
  localparam int S_BRK = 2;
  localparam int S_UNF = 3;
  localparam int ST_W = 4;
  // break modes
  typedef enum logic [1:0] {
    BRK_OFF = 2'b00,
    BRK_LOW = 2'b01,
    BRK_HIGH = 2'b10
  } brk_mode_t;
  // reset values, unity scale and scale fraction bits
  localparam logic [15:0] INC_RST = 16'h0100;
  localparam logic [15:0] SCALE_ONE = 16'h0100;
  localparam logic [7:0] REP_RST = 8'h01;
  localparam int SCALE_FRAC = 8;
endpackage

// ===== verilog/carrier_pwm.sv
// carrier pwm generator with blanking, triggers, break and sync
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module carrier_pwm import cpwm_pkg::*; #(
  parameter int DW = 16,
  parameter int BW = 8
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  // register port
  input wire logic [AW-1:0] ADDR_IN,
  input wire logic [31:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [31:0] RDATA_OUT,
  output logic IRQ_OUT,
  // frequency scale, 8.8 fixed point, same clock
  input wire logic [15:0] FSCALE_IN,
  // common start trigger, same clock
  input wire logic START_IN,
  // pins
  input wire logic SYNC_IN,
  input wire logic BRK_IN,
  input wire logic [2*NCH-1:0] EN_IN,
  // gate drive outputs
  output logic [NCH-1:0] PWM_OUT,
  output logic [NCH-1:0] PWMN_OUT,
  // trigger pulses
  output logic ADC_TRIG_OUT,
  output logic TASK_TRIG_OUT
);

  logic [CTRL_W-1:0] ctrl_q;
  logic [DW-1:0] inc_q;
  logic [DW-1:0] mod_q [NCH];
  logic [BW-1:0] blank_q;
  logic [3*NCH-1:0] chcfg_q;
  logic [7:0] rep_q;
  logic [ST_W-1:0] st_q;
  logic [ST_W-1:0] mask_q;
  logic [31:0] rdata_q;
  logic run_q;
  logic [DW-1:0] ph_q;
  logic [7:0] rcnt_q;
  logic brk_q;
  logic [2:0] sync_s_q;
  logic [2:0] brk_s_q;
  logic [2*NCH-1:0] en_a_q;
  logic [2*NCH-1:0] en_q;
  logic [DW-1:0] eff_inc;
  logic [DW+15:0] prod;
  logic [DW-1:0] carrier;
  logic [DW-1:0] ph_nx;
  logic sync_edge;
  logic brk_edge;
  logic unf_ev;
  logic ovf_ev;
  logic sel_ev;
  logic trig;
  logic [ST_W-1:0] ev;
  logic [NCH-1:0] comp_en;
  logic [NCH-1:0] pol_p;
  logic [NCH-1:0] pol_n;
  brk_mode_t bmode;

  assign bmode = brk_mode_t'(ctrl_q[C_BRK+1:C_BRK]);
  assign comp_en = chcfg_q[NCH-1:0];
  assign pol_p = chcfg_q[2*NCH-1:NCH];
  assign pol_n = chcfg_q[3*NCH-1:2*NCH];

  // register writes
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ctrl_q <= '0;
      inc_q <= INC_RST;
      blank_q <= '0;
      chcfg_q <= '0;
      rep_q <= REP_RST;
      mask_q <= '0;
    end else if (WR_IN) begin
      case (ADDR_IN)
        A_CTRL: ctrl_q <= WDATA_IN[CTRL_W-1:0];
        A_INC: inc_q <= WDATA_IN[DW-1:0];
        A_BLANK: blank_q <= WDATA_IN[BW-1:0];
        A_CHCFG: chcfg_q <= WDATA_IN[3*NCH-1:0];
        A_REP: rep_q <= WDATA_IN[7:0];
        A_MASK: mask_q <= WDATA_IN[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // modulation index registers, one word per channel
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      for (int i = 0; i < NCH; i++) mod_q[i] <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (WR_IN && ADDR_IN == A_MOD0 + AW'(4 * i)) mod_q[i] <= WDATA_IN[DW-1:0];
      end
    end
  end

  // read data, valid in the cycle after the strobe
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      rdata_q <= '0;
    end else if (RD_IN) begin
      case (ADDR_IN)
        A_CTRL: rdata_q <= 32'(ctrl_q);
        A_INC: rdata_q <= 32'(inc_q);
        A_BLANK: rdata_q <= 32'(blank_q);
        A_CHCFG: rdata_q <= 32'(chcfg_q);
        A_REP: rdata_q <= 32'(rep_q);
        A_STAT: rdata_q <= 32'(st_q);
        A_MASK: rdata_q <= 32'(mask_q);
        A_STATE: rdata_q <= 32'({PWMN_OUT, PWM_OUT, brk_q, run_q});
        default: begin
          rdata_q <= '0;
          for (int i = 0; i < NCH; i++) begin
            if (ADDR_IN == A_MOD0 + AW'(4 * i)) rdata_q <= 32'(mod_q[i]);
          end
        end
      endcase
    end else begin
      rdata_q <= '0;
    end
  end
  assign RDATA_OUT = rdata_q;

  // sticky status, cleared by read, a new event wins
  assign ev = {unf_ev, brk_edge, trig && ctrl_q[C_TASK], trig && ctrl_q[C_ADC]};
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) st_q <= '0;
    else st_q <= ((RD_IN && ADDR_IN == A_STAT) ? '0 : st_q) | ev;
  end
  assign IRQ_OUT = |(st_q & mask_q);

  // two-flop synchronisers, third stage for edge detect
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      sync_s_q <= '0;
      brk_s_q <= '0;
      en_a_q <= '0;
      en_q <= '0;
    end else begin
      sync_s_q <= {sync_s_q[1:0], SYNC_IN};
      brk_s_q <= {brk_s_q[1:0], BRK_IN};
      en_a_q <= EN_IN;
      en_q <= en_a_q;
    end
  end

  // sync edge select
  assign sync_edge = ctrl_q[C_SYNC] && (ctrl_q[C_SFALL] ?
    (sync_s_q[2] && !sync_s_q[1]) : (!sync_s_q[2] && sync_s_q[1]));

  // break edge per mode
  always_comb begin
    case (bmode)
      BRK_LOW: brk_edge = brk_s_q[2] && !brk_s_q[1];
      BRK_HIGH: brk_edge = !brk_s_q[2] && brk_s_q[1];
      default: brk_edge = 1'b0;
    endcase
  end

  // break latch, cleared by control write
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) brk_q <= 1'b0;
    else if (brk_edge) brk_q <= 1'b1;
    else if (WR_IN && ADDR_IN == A_CTRL && WDATA_IN[C_BCLR]) brk_q <= 1'b0;
  end

  // effective increment: nominal times scale
  assign prod = inc_q * (ctrl_q[C_FVAR] ? FSCALE_IN : SCALE_ONE);
  assign eff_inc = prod[DW-1+SCALE_FRAC:SCALE_FRAC];
  assign ph_nx = ph_q + eff_inc;

  // run state and phase accumulator
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      run_q <= 1'b0;
      ph_q <= '0;
    end else if (!ctrl_q[C_ARM]) begin
      run_q <= 1'b0;
      ph_q <= '0;
    end else if (sync_edge) begin
      run_q <= 1'b1;
      ph_q <= '0;
    end else if (!run_q) begin
      run_q <= START_IN && !ctrl_q[C_SYNC];
      ph_q <= '0;
    end else begin
      ph_q <= ph_nx;
    end
  end

  // carrier shape and events
  assign carrier = ctrl_q[C_SYM] ? {ph_q[DW-2:0], 1'b0} ^ {DW{ph_q[DW-1]}} : ph_q;
  assign unf_ev = run_q && (ph_nx < ph_q);
  assign ovf_ev = ctrl_q[C_SYM] ? (run_q && !ph_q[DW-1] && ph_nx[DW-1]) : unf_ev;
  assign sel_ev = ctrl_q[C_OVF] ? ovf_ev : unf_ev;

  // repetition counter
  assign trig = sel_ev && (rcnt_q + 8'h01 >= rep_q);
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN || !run_q) rcnt_q <= '0;
    else if (trig) rcnt_q <= '0;
    else if (sel_ev) rcnt_q <= rcnt_q + 8'h01;
  end

  // trigger pulses
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ADC_TRIG_OUT <= 1'b0;
      TASK_TRIG_OUT <= 1'b0;
    end else begin
      ADC_TRIG_OUT <= trig && ctrl_q[C_ADC];
      TASK_TRIG_OUT <= trig && ctrl_q[C_TASK];
    end
  end

  // per-channel compare, blanking and output stage
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic raw;
    logic act_q;
    logic [BW-1:0] bcnt_q;
    logic ena_p;
    logic ena_n;
    logic on_p;
    logic on_n;
    assign raw = run_q && (mod_q[c] > carrier);
    assign ena_p = !ctrl_q[C_ENUSE] || en_q[c];
    assign ena_n = !ctrl_q[C_ENUSE] || (ctrl_q[C_PEROUT] ? en_q[NCH+c] : en_q[c]);

    // blanking counter restarts on each compare change
    always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
        act_q <= 1'b0;
        bcnt_q <= '0;
      end else if (raw != act_q) begin
        act_q <= raw;
        bcnt_q <= comp_en[c] ? blank_q : '0;
      end else if (bcnt_q != '0) begin
        bcnt_q <= bcnt_q - BW'(1);
      end
    end

    assign on_p = act_q && (bcnt_q == '0 || !comp_en[c]);
    assign on_n = comp_en[c] && !act_q && run_q && bcnt_q == '0;

    // registered pins, passive is the inverse of polarity
    always_ff @(posedge CLK_IN) begin
      if (!RST_N_IN) begin
        PWM_OUT[c] <= 1'b0;
        PWMN_OUT[c] <= 1'b0;
      end else begin
        PWM_OUT[c] <= (on_p && ena_p && !brk_q) ? pol_p[c] : !pol_p[c];
        PWMN_OUT[c] <= (on_n && ena_n && !brk_q) ? pol_n[c] : !pol_n[c];
      end
    end

    pair_excl_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      $past(RST_N_IN) |->
        !((PWM_OUT[c] == $past(pol_p[c])) && (PWMN_OUT[c] == $past(pol_n[c]))))
      else $error("both pair outputs active");
    en_pass_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      (ctrl_q[C_ENUSE] && !en_q[c]) |=> (PWM_OUT[c] == !$past(pol_p[c])))
      else $error("disabled output not passive");
    single_pass_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
      (RST_N_IN && !comp_en[c]) |=> (PWMN_OUT[c] == !$past(pol_n[c])))
      else $error("single channel complement not passive");
  end

  brk_pass_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    brk_q |=> (PWM_OUT == ~$past(pol_p)) && (PWMN_OUT == ~$past(pol_n)))
    else $error("output active during break");
  brk_off_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (bmode == BRK_OFF && !brk_q) |=> !brk_q)
    else $error("break latched while disabled");
  idle_zero_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !run_q |-> (ph_q == '0))
    else $error("carrier not at zero while idle");
  start_go_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (ctrl_q[C_ARM] && !ctrl_q[C_SYNC] && START_IN && !run_q) |=> run_q ##1 run_q || !ctrl_q[C_ARM])
    else $error("start trigger missed");
  sync_rst_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (ctrl_q[C_ARM] && sync_edge) |=> (run_q && ph_q == '0))
    else $error("sync edge did not reset counter");
  phase_step_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (run_q && ctrl_q[C_ARM] && !sync_edge) |=> ph_q == $past(ph_q) + $past(eff_inc))
    else $error("phase step differs from scaled increment");
  rep_cnt_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ADC_TRIG_OUT |-> $past(sel_ev) && ($past(rcnt_q) + 8'h01 >= $past(rep_q)))
    else $error("trigger before repetition period");
  trig_en_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (trig && !ctrl_q[C_TASK]) |=> !TASK_TRIG_OUT)
    else $error("task trigger while disabled");
  stat_keep_a: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (st_q[S_ADC] && !(RD_IN && ADDR_IN == A_STAT)) |=> st_q[S_ADC])
    else $error("adc status lost without a read");
endmodule

// ===== bench/gate_stage.sv
// gate driver model: fault and ready lines, shoot-through watch
`timescale 1ns/1ps
module gate_stage (
  // clock
  input wire logic clk_in,
  // commands from the bench
  input wire logic trip_in,
  input wire logic [7:0] ready_in,
  // gate drive from the generator
  input wire logic [3:0] hi_in,
  input wire logic [3:0] lo_in,
  // lines back to the generator
  output logic brk_out,
  output logic [7:0] en_out,
  output int shoot_out
);
  // fault line and driver ready lines follow the commands
  assign brk_out = trip_in;
  assign en_out = ready_in;
  // both switches of an active-high leg closed at once
  int hits = 0;
  assign shoot_out = hits;
  always @(posedge clk_in) begin
    if ((hi_in[1:0] & lo_in[1:0]) != 2'h0) begin
      hits <= hits + 1;
    end
  end
endmodule

// ===== bench/carrier_pwm_bench.sv
// self-checking bench for the carrier pwm generator
`timescale 1ns/1ps
module carrier_pwm_bench import cpwm_pkg::*; ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [31:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] fscale = SCALE_ONE;
  logic start = 1'b0;
  logic sync = 1'b0;
  logic trip = 1'b0;
  logic [7:0] ready = 8'hff;
  logic [31:0] rdata;
  logic irq, brk, adc, tsk;
  logic [7:0] en;
  logic [3:0] pwm, pwmn;
  int shoot, shoot0, t1, t2;
  int d[2];
  int cyc = 0;
  int err_count = 0;
  int tests_run = 0;

  // clock and cycle stamp
  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  carrier_pwm uut (.CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq), .FSCALE_IN(fscale),
    .START_IN(start), .SYNC_IN(sync), .BRK_IN(brk), .EN_IN(en), .PWM_OUT(pwm),
    .PWMN_OUT(pwmn), .ADC_TRIG_OUT(adc), .TASK_TRIG_OUT(tsk));
  gate_stage stage (.clk_in(clk), .trip_in(trip), .ready_in(ready), .hi_in(pwm),
    .lo_in(pwmn), .brk_out(brk), .en_out(en), .shoot_out(shoot));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one-cycle write strobe, then a gap cycle
  task automatic wr_reg(input logic [AW-1:0] a, input logic [31:0] dat);
    addr <= a;
    wdata <= dat;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // read data stands in the cycle after the strobe
  task automatic rd_chk(input logic [AW-1:0] a, input logic [31:0] m, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk(rdata & m, e);
  endtask

  // stop, load a control word, pulse the common start
  task automatic run(input logic [31:0] ctl);
    wr_reg(A_CTRL, 32'h0);
    wr_reg(A_CTRL, ctl);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
  endtask

  // stamp of the next edge where the chosen pin reads lvl
  task automatic wait_for(input int sel, input logic lvl, output int t);
    logic s;
    t = -1;
    for (int i = 0; i < 400 && t < 0; i++) begin
      @(posedge clk);
      s = (sel == 0) ? adc : (sel == 1) ? pwm[0] : pwmn[0];
      if (s === lvl) t = cyc;
    end
  endtask

  task automatic end_of_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #1000000;
    err_count++;
    end_of_test();
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(A_CTRL, 32'hffffffff, 32'h0);
    rd_chk(A_INC, 32'hffffffff, {16'h0, INC_RST});
    rd_chk(A_REP, 32'hffffffff, {24'h0, REP_RST});
    rd_chk(6'h3c, 32'hffffffff, 32'h0);
    // pairs on ch0 and ch1 driven active high, ch0 full index, ch1 zero
    wr_reg(A_CHCFG, 32'h333);
    wr_reg(A_MOD0, 32'hffff);
    wr_reg(A_MOD0 + 6'h4, 32'h0);
    wr_reg(A_INC, 32'h1000);
    wr_reg(A_REP, 32'h3);
    wr_reg(A_MASK, 32'h1);
    shoot0 = shoot;
    run(32'h0);
    rd_chk(A_STATE, 32'h1, 32'h0);
    run(32'h181);
    rd_chk(A_STATE, 32'h1, 32'h1);
    cyc_wait(40);
    chk(32'(pwm), 32'hd);
    chk(32'(pwmn), 32'he);
    wait_for(0, 1'b1, t1);
    chk(32'(tsk), 32'h1);
    wait_for(0, 1'b1, t2);
    chk(32'(t2 - t1), 32'h30);
    chk(32'(irq), 32'h1);
    rd_chk(A_STAT, 32'h1, 32'h1);
    wr_reg(A_CTRL, 32'h0);
    rd_chk(A_STAT, 32'hf, 32'h0);
    rd_chk(A_STAT, 32'hf, 32'h0);
    chk(32'(irq), 32'h0);
    // symmetrical carrier, underflow then overflow placement
    wr_reg(A_MASK, 32'h2);
    wr_reg(A_REP, 32'h2);
    for (int i = 0; i < 2; i++) begin
      run(i ? 32'hc3 : 32'h83);
      t1 = cyc;
      wait_for(0, 1'b1, t2);
      d[i] = t2 - t1;
    end
    chk(32'((d[1] - d[0] + 64) % 16), 32'h8);
    wait_for(0, 1'b1, t1);
    chk(32'(t1 - t2), 32'h20);
    chk(32'(irq), 32'h0);
    // frequency scale at half and double rate
    wr_reg(A_REP, 32'h1);
    run(32'h881);
    for (int i = 0; i < 2; i++) begin
      fscale <= i ? 16'h0200 : 16'h0080;
      wait_for(0, 1'b1, t1);
      wait_for(0, 1'b1, t2);
      chk(32'(t2 - t1), i ? 32'h8 : 32'h20);
    end
    // a rising, then a falling sync edge restarts the carrier at the same phase
    run(32'h91);
    for (int i = 0; i < 2; i++) begin
      if (i == 1) wr_reg(A_CTRL, 32'hb1);
      sync <= ~sync;
      t1 = cyc;
      wait_for(0, 1'b1, t2);
      d[i] = t2 - t1;
      cyc_wait(5);
    end
    chk(32'(d[0]), 32'h14);
    chk(32'(d[1]), 32'(d[0]));
    // enables per channel, then per output
    run(32'h401);
    ready <= 8'hfe;
    cyc_wait(40);
    chk(32'(pwm), 32'hc);
    chk(32'(pwmn), 32'he);
    wr_reg(A_CTRL, 32'h601);
    ready <= 8'hdf;
    cyc_wait(40);
    chk(32'(pwm), 32'hd);
    chk(32'(pwmn), 32'hc);
    ready <= 8'hff;
    // break off, active low, active high; each pass toggles the fault line
    for (int i = 0; i < 3; i++) begin
      wr_reg(A_CTRL, 32'h601 | (32'(i) << C_BRK));
      trip <= ~trip;
      cyc_wait(8);
      chk(32'(pwm), i ? 32'hc : 32'hd);
      chk(32'(pwmn), i ? 32'hc : 32'he);
      rd_chk(A_STATE, 32'h2, i ? 32'h2 : 32'h0);
      wr_reg(A_CTRL, 32'h1601 | (32'(i) << C_BRK));
      cyc_wait(40);
      chk(32'(pwm), 32'hd);
    end
    // blanking gap between primary fall and complementary rise
    wr_reg(A_BLANK, 32'h5);
    wr_reg(A_MOD0, 32'h8000);
    run(32'h1);
    wait_for(1, 1'b1, t1);
    wait_for(1, 1'b0, t1);
    wait_for(2, 1'b1, t2);
    chk(32'(t2 - t1), 32'h5);
    chk(32'(shoot - shoot0), 32'h0);
    end_of_test();
  end
endmodule
